//--- design/sprc_pkg.sv
// Package of offsets, field positions and reset values for the control block
package sprc_pkg;
  // Register offsets
  localparam logic [7:0] POWER_CONFIGURATION_ADDR  = 8'h0c;
  localparam logic [7:0] BLOCK_RESET_CONTROL_ADDR  = 8'h0e;
  localparam logic [7:0] OUTPUT_DRIVE_CONTROL_ADDR = 8'h12;
  localparam logic [7:0] BIAS_LEVEL_ADDR           = 8'h13;
  // Power configuration fields
  localparam int PWR_STANDBY_BIT    = 0;
  localparam int PWR_CLAMP_FORCE    = 1;
  localparam int PWR_CLAMP_SRC      = 2;
  localparam int PWR_BIAS_EXT_RES   = 3;
  localparam int PWR_BIAS_GEN_EN    = 4;
  localparam logic [7:0] PWR_USED_MASK = 8'h1f;
  // Reset control fields
  localparam int RST_FULL_SOFT      = 0;
  localparam int RST_STATE          = 1;
  localparam int RST_SENSOR_IF      = 2;
  localparam int RST_POST_ADC       = 3;
  localparam int RST_CONV_CHAIN     = 4;
  localparam logic [7:0] RST_USED_MASK = 8'h1f;
  // Output drive fields and bias level mask
  localparam int DRV_PIXEL_BUS      = 0;
  localparam int DRV_CTRL_OUTS      = 1;
  localparam logic [7:0] DRV_USED_MASK = 8'h03;
  localparam logic [7:0] BIAS_USED_MASK = 8'h7f;
  // Reset values
  localparam logic [7:0] POWER_CONFIGURATION_RST  = 8'h00;
  localparam logic [7:0] BLOCK_RESET_CONTROL_RST  = 8'h00;
  localparam logic [7:0] OUTPUT_DRIVE_CONTROL_RST = 8'h02;
  localparam logic [7:0] BIAS_LEVEL_RST           = 8'h00;
  localparam logic [7:0] STATE_RST                = 8'h00;
endpackage : sprc_pkg

//--- design/sprc_ctl.sv
// Power, block reset and output drive control registers of the sensor
`timescale 1ns/1ps
`default_nettype none
module sprc_ctl (
  // Clock and reset
  input  wire  logic       i_core_clk,
  input  wire  logic       i_resetn,
  // Register write and read port
  input  wire  logic       i_reg_wr,
  input  wire  logic       i_reg_rd,
  input  wire  logic [7:0] i_reg_addr,
  input  wire  logic [7:0] i_reg_wdata,
  output var   logic [7:0] o_reg_rdata,
  output var   logic       o_reg_rvalid,
  // Block state inputs to hold, one byte per block
  input  wire  logic       i_if_load,
  input  wire  logic [7:0] i_if_data,
  input  wire  logic       i_pad_load,
  input  wire  logic [7:0] i_pad_data,
  input  wire  logic       i_asp_load,
  input  wire  logic [7:0] i_asp_data,
  // Power controls
  output var   logic       o_soft_standby,
  output var   logic       o_bias_gen_en,
  output var   logic       o_bias_ext_res,
  output var   logic       o_clamp_force_on,
  output var   logic       o_clamp_internal,
  output var   logic [6:0] o_bias_level,
  // Block states and hold-in-reset levels
  output var   logic [7:0] o_if_state,
  output var   logic [7:0] o_pad_state,
  output var   logic [7:0] o_asp_state,
  output var   logic       o_run_halt,
  // Output enables, low while driving
  output var   logic       o_ctrl_outs_oe_n,
  output var   logic       o_pixel_bus_oe_n
);

  // Register storage
  logic [7:0] power_configuration;
  logic [7:0] block_reset_control;
  logic [7:0] output_drive_control;
  logic [7:0] bias_level;
  logic       next_full_rst;
  logic       wr_pwr;
  logic       wr_rst;
  logic       wr_drv;
  logic       wr_bias;

  // Address match helper used by each write strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_pwr  = i_reg_wr
                && hit(i_reg_addr, sprc_pkg::POWER_CONFIGURATION_ADDR);
  assign wr_rst  = i_reg_wr
                && hit(i_reg_addr, sprc_pkg::BLOCK_RESET_CONTROL_ADDR);
  assign wr_drv  = i_reg_wr
                && hit(i_reg_addr, sprc_pkg::OUTPUT_DRIVE_CONTROL_ADDR);
  assign wr_bias = i_reg_wr && hit(i_reg_addr, sprc_pkg::BIAS_LEVEL_ADDR);

  // Full reset from pin or full soft reset bit
  // full soft reset
  assign next_full_rst = !i_resetn
                      || block_reset_control[sprc_pkg::RST_FULL_SOFT];

  // Power configuration register, unused bits kept zero
  // standby bit stored
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst) begin
      power_configuration <= sprc_pkg::POWER_CONFIGURATION_RST;
    end else if (wr_pwr) begin
      power_configuration <= i_reg_wdata & sprc_pkg::PWR_USED_MASK;
    end
  end

  // Reset control register; only the pin clears it, host writes 0 back
  // host clears bits
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      block_reset_control <= sprc_pkg::BLOCK_RESET_CONTROL_RST;
    end else if (wr_rst) begin
      block_reset_control <= i_reg_wdata & sprc_pkg::RST_USED_MASK;
    end
  end

  // Output drive control register
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst) begin
      output_drive_control <= sprc_pkg::OUTPUT_DRIVE_CONTROL_RST;
    end else if (wr_drv) begin
      output_drive_control <= i_reg_wdata & sprc_pkg::DRV_USED_MASK;
    end
  end

  // Bias level register
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst) begin
      bias_level <= sprc_pkg::BIAS_LEVEL_RST;
    end else if (wr_bias) begin
      bias_level <= i_reg_wdata & sprc_pkg::BIAS_USED_MASK;
    end
  end

  // Sensor interface state, cleared by its own, state or full reset
  // sensor if reset
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst
        || block_reset_control[sprc_pkg::RST_SENSOR_IF]
        || block_reset_control[sprc_pkg::RST_STATE]) begin
      o_if_state <= sprc_pkg::STATE_RST;
    end else if (i_if_load && !o_soft_standby) begin
      o_if_state <= i_if_data;
    end
  end

  // Post converter state
  // post adc reset
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst
        || block_reset_control[sprc_pkg::RST_POST_ADC]
        || block_reset_control[sprc_pkg::RST_STATE]) begin
      o_pad_state <= sprc_pkg::STATE_RST;
    end else if (i_pad_load && !o_soft_standby) begin
      o_pad_state <= i_pad_data;
    end
  end

  // Converter chain state, cleared to zero
  // chain reset
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst
        || block_reset_control[sprc_pkg::RST_CONV_CHAIN]
        || block_reset_control[sprc_pkg::RST_STATE]) begin
      o_asp_state <= sprc_pkg::STATE_RST;
    end else if (i_asp_load && !o_soft_standby) begin
      o_asp_state <= i_asp_data;
    end
  end

  // Halt while state or full reset bit is still set
  // resume on clear
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_run_halt <= 1'b1;
    end else begin
      o_run_halt <= block_reset_control[sprc_pkg::RST_STATE]
                 || block_reset_control[sprc_pkg::RST_FULL_SOFT];
    end
  end

  // Power control outputs decoded from the register
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst) begin
      o_soft_standby   <= 1'b0;
      o_bias_gen_en    <= 1'b0;
      o_bias_ext_res   <= 1'b0;
      o_clamp_force_on <= 1'b0;
      o_clamp_internal <= 1'b1;
      o_bias_level     <= 7'h00;
    end else begin
      o_soft_standby   <= power_configuration[sprc_pkg::PWR_STANDBY_BIT];
      o_bias_gen_en    <= power_configuration[sprc_pkg::PWR_BIAS_GEN_EN];
      o_bias_ext_res   <= power_configuration[sprc_pkg::PWR_BIAS_EXT_RES];
      o_clamp_force_on <= power_configuration[sprc_pkg::PWR_CLAMP_SRC]
                       && power_configuration[sprc_pkg::PWR_CLAMP_FORCE];
      o_clamp_internal <= !power_configuration[sprc_pkg::PWR_CLAMP_SRC];
      o_bias_level     <= power_configuration[sprc_pkg::PWR_BIAS_GEN_EN]
                        ? bias_level[6:0] : 7'h00;
    end
  end

  // Output enables, active low
  always_ff @(posedge i_core_clk) begin
    if (next_full_rst) begin
      o_ctrl_outs_oe_n <= 1'b0;
      o_pixel_bus_oe_n <= 1'b1;
    end else begin
      o_ctrl_outs_oe_n <= !output_drive_control[sprc_pkg::DRV_CTRL_OUTS];
      o_pixel_bus_oe_n <= !output_drive_control[sprc_pkg::DRV_PIXEL_BUS];
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          sprc_pkg::POWER_CONFIGURATION_ADDR:
            o_reg_rdata <= power_configuration;
          sprc_pkg::BLOCK_RESET_CONTROL_ADDR:
            o_reg_rdata <= block_reset_control;
          sprc_pkg::OUTPUT_DRIVE_CONTROL_ADDR:
            o_reg_rdata <= output_drive_control;
          sprc_pkg::BIAS_LEVEL_ADDR:
            o_reg_rdata <= bias_level;
          default:
            o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule : sprc_ctl
`default_nettype wire

//--- testbench/sprc_ctl_asserts.sv
// Checker for the sensor control registers
`timescale 1ns/1ps
`default_nettype none
module sprc_ctl_asserts (
  // Watched ports
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       o_reg_rvalid,
  input wire logic [7:0] o_if_state,
  input wire logic [7:0] o_pad_state,
  input wire logic [7:0] o_asp_state,
  input wire logic       o_soft_standby,
  input wire logic       o_bias_gen_en,
  input wire logic       o_clamp_force_on,
  input wire logic       o_clamp_internal,
  input wire logic       o_run_halt,
  input wire logic       o_ctrl_outs_oe_n,
  input wire logic       o_pixel_bus_oe_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // Writes to power and drive registers
  sequence s_pw;
    i_reg_wr && i_reg_addr == 8'h0c && !o_run_halt;
  endsequence
  sequence s_dw;
    i_reg_wr && i_reg_addr == 8'h12 && !o_run_halt;
  endsequence
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  a_standby_bit: assert property (
    s_pw |=> ##1 o_soft_standby == $past(i_reg_wdata[0], 2))
    else $error("standby wrong");
  a_bias_gen: assert property (
    s_pw |=> ##1 o_bias_gen_en == $past(i_reg_wdata[4], 2))
    else $error("bias enable wrong");
  a_clamp_pick: assert property (s_pw |=> ##1
    o_clamp_force_on == ($past(i_reg_wdata[2], 2) & $past(i_reg_wdata[1], 2))
    && o_clamp_internal == !$past(i_reg_wdata[2], 2))
    else $error("clamp wrong");
  a_ctrl_drive: assert property (
    s_dw |=> ##1 o_ctrl_outs_oe_n == !$past(i_reg_wdata[1], 2))
    else $error("control enable wrong");
  a_pixel_drive: assert property (
    s_dw |=> ##1 o_pixel_bus_oe_n == !$past(i_reg_wdata[0], 2))
    else $error("pixel enable wrong");
  a_if_clear: assert property (i_reg_wr && i_reg_addr == 8'h0e
    && i_reg_wdata[2] |=> ##1 o_if_state == 8'h00)
    else $error("interface state kept");
  a_pad_clear: assert property (i_reg_wr && i_reg_addr == 8'h0e
    && i_reg_wdata[3] |=> ##1 o_pad_state == 8'h00)
    else $error("post converter state kept");
  a_asp_clear: assert property (i_reg_wr && i_reg_addr == 8'h0e
    && i_reg_wdata[4] |=> ##1 o_asp_state == 8'h00)
    else $error("converter chain state kept");
  a_full_defaults: assert property (i_reg_wr && i_reg_addr == 8'h0e
    && i_reg_wdata[0] |=> ##1 !o_soft_standby && o_clamp_internal
    && !o_ctrl_outs_oe_n && o_pixel_bus_oe_n)
    else $error("full soft reset defaults wrong");
  a_halt_level: assert property (i_reg_wr && i_reg_addr == 8'h0e
    |=> ##1 o_run_halt == |$past(i_reg_wdata[1:0], 2))
    else $error("halt level wrong");
  // Main scenarios seen
  c_power: cover property (s_pw);
  c_read: cover property (i_reg_rd ##1 o_reg_rvalid);
  c_halt: cover property (o_run_halt);
  c_full_soft: cover property (i_reg_wr && i_reg_addr == 8'h0e
    && i_reg_wdata[0]);
endmodule : sprc_ctl_asserts
bind sprc_ctl sprc_ctl_asserts i_sprc_ctl_asserts (.*);
`default_nettype wire

//--- testbench/sprc_host.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module sprc_host (
  // Clock and read return
  input  wire logic       i_core_clk,
  input  wire logic       o_reg_rvalid,
  input  wire logic [7:0] o_reg_rdata,
  // Access strobes
  output var  logic       i_reg_wr,
  output var  logic       i_reg_rd,
  output var  logic [7:0] i_reg_addr,
  output var  logic [7:0] i_reg_wdata
);
  initial {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
  // callers pass zero in unused bits
  task automatic wr(input logic [7:0] a, d);
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_core_clk);
    i_reg_wr = 0;
    i_reg_wdata = ~d;
  endtask : wr
  // Read with a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output bit ok);
    int n;
    @(negedge i_core_clk);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_core_clk);
    i_reg_rd = 0;
    for (n = 0; n < 4 && o_reg_rvalid !== 1'b1; n++) begin
      @(negedge i_core_clk);
    end
    ok = (o_reg_rvalid === 1'b1);
    q = o_reg_rdata;
  endtask : rd
endmodule : sprc_host
`default_nettype wire

//--- testbench/sprc_ctl_tb.sv
// Testbench of the sensor control registers
`timescale 1ns/1ps
`default_nettype none
module sprc_ctl_tb;
  logic i_core_clk = 0, i_resetn = 0, i_reg_wr, i_reg_rd, o_reg_rvalid;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_if_state;
  logic [7:0] o_pad_state, o_asp_state, v;
  logic i_if_load = 0, i_pad_load = 0, i_asp_load = 0;
  logic [7:0] i_if_data = 0, i_pad_data = 0, i_asp_data = 0;
  logic o_soft_standby, o_bias_gen_en, o_bias_ext_res, o_clamp_force_on;
  logic o_clamp_internal, o_run_halt, o_ctrl_outs_oe_n, o_pixel_bus_oe_n;
  logic [6:0] o_bias_level;
  logic [7:0] pv[7] = '{8'h01, 8'h02, 8'h06, 8'h04, 8'h08, 8'h10, 8'h1f};
  logic [7:0] rs[5] = '{8'h04, 8'h08, 8'h10, 8'h1c, 8'h02};
  int err_total = 0, compares = 0, i;
  wire logic [7:0] pw = {3'h0, o_bias_gen_en, o_bias_ext_res,
                         o_clamp_internal, o_clamp_force_on, o_soft_standby};
  wire logic [7:0] oe = {6'h0, o_ctrl_outs_oe_n, o_pixel_bus_oe_n};
  always #10 i_core_clk = ~i_core_clk;
  sprc_ctl i_sprc_ctl (.*);
  sprc_host i_sprc_host (.*);
  task automatic give_verdict(input bit t);
    err_total += t;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] g, e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, d);
    i_sprc_host.wr(a, d);
    @(negedge i_core_clk);
  endtask : w
  task automatic r(input logic [7:0] a, e);
    logic [7:0] q;
    bit ok;
    i_sprc_host.rd(a, q, ok);
    if (!ok) give_verdict(1);
    chk(q, e);
  endtask : r
  // Load one byte into every block state
  task automatic load();
    @(negedge i_core_clk);
    {i_if_data, i_pad_data, i_asp_data} = {3{8'h5a}};
    {i_if_load, i_pad_load, i_asp_load} = 3'h7;
    @(negedge i_core_clk);
    {i_if_load, i_pad_load, i_asp_load} = 3'h0;
    @(negedge i_core_clk);
  endtask : load
  // Main sequence
  initial begin
    repeat (10) @(negedge i_core_clk);
    i_resetn = 1;
    r(8'h0c, 8'h00);
    r(8'h12, 8'h02);
    chk(oe, 8'h01);
    $display("reset test done");
    foreach (pv[i]) begin
      v = pv[i];
      w(8'h0c, v);
      chk(pw, {3'h0, v[4], v[3], ~v[2], v[2] & v[1], v[0]});
    end
    r(8'h0c, 8'h1f);
    w(8'h13, 8'h7f);
    w(8'h0c, 8'h00);
    chk({1'b0, o_bias_level}, 8'h00);
    w(8'h0c, 8'h10);
    chk({1'b0, o_bias_level}, 8'h7f);
    $display("power test done");
    for (i = 0; i < 4; i++) begin
      w(8'h12, 8'(i));
      chk(oe, {6'h0, ~2'(i)});
    end
    $display("drive test done");
    w(8'h0c, 8'h08);
    foreach (rs[i]) begin
      v = rs[i];
      load();
      w(8'h0e, v);
      chk(o_if_state, (v[2] | v[1]) ? 8'h00 : 8'h5a);
      chk(o_pad_state, (v[3] | v[1]) ? 8'h00 : 8'h5a);
      chk(o_asp_state, (v[4] | v[1]) ? 8'h00 : 8'h5a);
      chk({7'h0, o_run_halt}, {7'h0, v[1]});
      w(8'h0e, 8'h00);
    end
    r(8'h0c, 8'h08);
    $display("block reset test done");
    w(8'h12, 8'h00);
    w(8'h0e, 8'h01);
    chk(oe, 8'h01);
    chk({7'h0, o_run_halt}, 8'h01);
    r(8'h0c, 8'h00);
    r(8'h12, 8'h02);
    r(8'h0e, 8'h01);
    w(8'h0e, 8'h00);
    chk({7'h0, o_run_halt}, 8'h00);
    w(8'h20, 8'h55);
    r(8'h20, 8'h00);
    $display("soft reset test done");
    // Init pin pulled mid-run must restore defaults
    w(8'h0c, 8'h1f);
    w(8'h12, 8'h00);
    i_resetn = 0;
    repeat (2) @(negedge i_core_clk);
    chk({7'h0, o_run_halt}, 8'h01);
    i_resetn = 1;
    r(8'h0c, 8'h00);
    chk(pw, 8'h04);
    chk(oe, 8'h01);
    $display("pin reset test done");
    give_verdict(0);
  end
endmodule : sprc_ctl_tb
`default_nettype wire
